// *** inc/asd_consts.svh ***
// constants for the audio serial dma port
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

// data path sizes
`define ASD_WORD_W      32
`define ASD_FIFO_DEPTH  32
`define ASD_FIFO_FREE   6'h20
`define ASD_ONES        32'hFFFF_FFFF
`define ASD_WORD_BYTES  32'h0000_0004

// valid bits per channel sample
`define ASD_BITS_8      5'h08
`define ASD_BITS_16     5'h10
`define ASD_BITS_18     5'h12
`define ASD_BITS_20     5'h14
`define ASD_BITS_24     5'h18

// slot timing: msb leaves one bit clock after the slot starts
`define ASD_FIRST_BIT   5'h01

// ahb encodings
`define ASD_HTRANS_IDLE   2'h0
`define ASD_HTRANS_NONSEQ 2'h2
`define ASD_HTRANS_SEQ    2'h3
`define ASD_HBURST_INCR4  3'h3
`define ASD_HBURST_INCR8  3'h5
`define ASD_HBURST_INCR16 3'h7
`define ASD_HSIZE_WORD    3'h2

// beats per burst
`define ASD_BEATS_4     5'h04
`define ASD_BEATS_8     5'h08
`define ASD_BEATS_16    5'h10

`endif

// *** inc/asd_pkg.sv ***
// types shared by the audio serial dma port
package asd_pkg;
  // sample precision codes
  typedef enum logic [2:0] {
    ASD_P8  = 3'h0,
    ASD_P16 = 3'h1,
    ASD_P18 = 3'h2,
    ASD_P20 = 3'h3,
    ASD_P24 = 3'h4
  } asd_prec_t;

  // control bits from the cpu side
  typedef struct packed {
    logic        enable;
    logic        recordMode;
    logic        pcmMode;
    logic        clkMaster;
    asd_prec_t   precision;
    logic        burstDepthSelect;
    logic [7:0]  clkDiv;
    logic [31:0] baseLeft;
    logic [31:0] baseRight;
    logic [15:0] bufWords;
  } asd_ctrl_t;

  // status seen by the cpu side
  typedef struct packed {
    logic busy;
    logic overrun;
    logic underrun;
  } asd_stat_t;

  // dma sequencer states, one-hot
  typedef enum logic [2:0] {
    ASD_IDLE  = 3'h1,
    ASD_REQ   = 3'h2,
    ASD_BURST = 3'h4
  } asd_dma_st_t;
endpackage : asd_pkg

// *** logic/asd_mem.sv ***
// small word memory with registered read data
module asd_mem #(
  parameter int W = 32,
  parameter int D = 32
) (
  // system
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // write port
  input  wire logic                 wrEn,
  input  wire logic [$clog2(D)-1:0] wrAddr,
  input  wire logic [W-1:0]         wrData,
  // read port
  input  wire logic [$clog2(D)-1:0] rdAddr,
  output logic      [W-1:0]         rdData
);
  logic [W-1:0] store [D];

  // write and registered read, read returns old data on a same-address write
  always_ff @(posedge clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    if (!reset_n) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end
endmodule : asd_mem

// *** logic/asd_fifo.sv ***
// parameterised fifo with valid/ready on both sides
module asd_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // system
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               flush,
  // filling side
  input  wire logic               inValid,
  output logic                    inReady,
  input  wire logic [W-1:0]       inData,
  // draining side
  output logic                    outValid,
  input  wire logic               outReady,
  output logic [W-1:0]            outData,
  output logic [$clog2(D):0]      count
);
  localparam int AW = $clog2(D);
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0]   next_count;
  logic          stale, next_stale, doWr, doRd;

  // handshakes; stale masks the cycle after a write hits the head slot
  assign inReady  = (count != (AW+1)'(D));
  assign doWr     = inValid && inReady;
  assign outValid = (count != '0) && !stale;
  assign doRd     = outValid && outReady;

  // pointer and level update
  always_comb begin
    next_wrPtr = wrPtr + AW'(doWr);
    next_rdPtr = rdPtr + AW'(doRd);
    next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
    next_stale = doWr && (wrPtr == next_rdPtr);
    if (flush) begin
      next_wrPtr = '0;
      next_rdPtr = '0;
      next_count = '0;
      next_stale = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      stale <= 1'b0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      stale <= next_stale;
    end
  end

  // storage, read address runs one step ahead so the head is always registered
  asd_mem #(.W(W), .D(D)) uMem (
    .clk    (clk),
    .reset_n(reset_n),
    .wrEn   (doWr && !flush),
    .wrAddr (wrPtr),
    .wrData (inData),
    .rdAddr (next_rdPtr),
    .rdData (outData)
  );
endmodule : asd_fifo

// *** logic/asd_port.sv ***
// audio serial port: i2s/pcm codec link, channel fifos and ahb burst dma
// Summary of operation
// - Samples of 8, 16, 18, 20 and 24 bits are handled for record and playback on i2s and pcm.
// - At 18, 20 or 24 bits each left or right sample sits in its own 32-bit word.
// - Wide samples are msb-justified in the word and all lower bits are zero.
// - At 16 bits one word holds a pair, right sample in the upper half and left in the lower.
// - At 16 bits the dma bursts are incr8 with depth select 0 and incr4 with depth select 1.
// - At 18, 20 or 24 bits the dma bursts are incr16 with depth select 0 and incr8 with depth select 1.
// - The bus lock stays asserted for the whole of every burst.
// - A progress interrupt fires at one eighth, one quarter, one half and the end of the left or slot-one buffer only.
// - Sample data moves over an ahb master and the cpu reaches the control bits over its own port.
// - I2s carries left and right data and runs as clock master or clock slave.
// - Pcm runs two slots and is always clock master.
// - At 8, 18, 20 or 24 bits the dma keeps separate base addresses for left or slot one and right or slot two data.
`include "asd_consts.svh"
module asd_port (
  // system
  input  wire logic               clk,
  input  wire logic               reset_n,
  // control and status
  input  wire asd_pkg::asd_ctrl_t ctrl,
  output asd_pkg::asd_stat_t      stat,
  output logic                    dmaIrq,
  // codec link
  input  wire logic               bclkIn,
  output logic                    bclkOut,
  output logic                    bclkOe,
  input  wire logic               wsIn,
  output logic                    wsOut,
  output logic                    wsOe,
  input  wire logic               sdIn,
  output logic                    sdOut,
  output logic                    sdOe,
  // ahb master
  output logic                    HBUSREQ,
  output logic                    HLOCK,
  input  wire logic               HGRANT,
  input  wire logic               HREADY,
  output logic [31:0]             HADDR,
  output logic [1:0]              HTRANS,
  output logic [2:0]              HBURST,
  output logic [2:0]              HSIZE,
  output logic                    HWRITE,
  output logic [31:0]             HWDATA,
  input  wire logic [31:0]        HRDATA
);
  import asd_pkg::*;

  // ********************************************************
  // decode helpers
  // ********************************************************
  // valid bits per channel
  function automatic logic [4:0] precBits(input asd_prec_t p);
    case (p)
      ASD_P8:  precBits = `ASD_BITS_8;
      ASD_P16: precBits = `ASD_BITS_16;
      ASD_P18: precBits = `ASD_BITS_18;
      ASD_P20: precBits = `ASD_BITS_20;
      default: precBits = `ASD_BITS_24;
    endcase
  endfunction : precBits

  // keeps the msb-justified valid bits of a word
  function automatic logic [31:0] precMask(input asd_prec_t p);
    precMask = ~(`ASD_ONES >> precBits(p));
  endfunction : precMask

  logic        isPacked, isMaster, slot;
  logic [4:0]  nb, pos, nBeats;
  assign isPacked = (ctrl.precision == ASD_P16);
  assign isMaster = ctrl.clkMaster || ctrl.pcmMode;
  assign nb       = precBits(ctrl.precision);
  // burst length by packing and depth select
  assign nBeats   = isPacked ? (ctrl.burstDepthSelect ? `ASD_BEATS_4 : `ASD_BEATS_8)
                             : (ctrl.burstDepthSelect ? `ASD_BEATS_8 : `ASD_BEATS_16);

  // ********************************************************
  // link sampling and bit timing
  // ********************************************************
  logic [2:0] bclkS, wsS;
  logic [1:0] sdS;
  logic [7:0] divCnt, next_divCnt;
  logic       bclk, next_bclk, next_wsOut, rise, fall, wsLast, next_wsLast;
  logic [5:0] bitCnt, next_bitCnt;
  assign slot = bitCnt[5];
  assign pos  = bitCnt[4:0];

  // edge events from own divider or from the synchronised codec clock
  always_comb begin
    next_divCnt = divCnt + 8'h01;
    next_bclk   = bclk;
    next_bitCnt = bitCnt;
    next_wsLast = wsLast;
    rise        = 1'b0;
    fall        = 1'b0;
    if (isMaster) begin
      if (divCnt >= ctrl.clkDiv) begin
        next_divCnt = 8'h00;
        next_bclk   = ~bclk;
        rise        = ~bclk;
        fall        = bclk;
      end
    end else begin
      rise = bclkS[1] & ~bclkS[2];
      fall = ~bclkS[1] & bclkS[2];
    end
    // a slave restarts the count at every word select change, so a bad start heals at the next slot
    if (fall) begin
      next_bitCnt = (!isMaster && (wsS[1] != wsLast)) ? {wsS[1], 5'h00} : bitCnt + 6'h01;
      next_wsLast = wsS[1];
    end
    if (!ctrl.enable) begin
      next_divCnt = 8'h00;
      next_bclk   = 1'b0;
      next_bitCnt = '1;
    end
    // i2s select is the slot, pcm sync is one bit wide at frame start
    next_wsOut = ctrl.pcmMode ? (next_bitCnt == '0) : next_bitCnt[5];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bclkS  <= '0;
      wsS    <= '0;
      sdS    <= '0;
      divCnt <= 8'h00;
      bclk   <= 1'b0;
      bitCnt <= '1;
      wsOut  <= 1'b0;
      wsLast <= 1'b0;
    end else begin
      bclkS  <= {bclkS[1:0], bclkIn};
      wsS    <= {wsS[1:0], wsIn};
      sdS    <= {sdS[0], sdIn};
      divCnt <= next_divCnt;
      bclk   <= next_bclk;
      bitCnt <= next_bitCnt;
      wsOut  <= next_wsOut;
      wsLast <= next_wsLast;
    end
  end

  assign bclkOut = bclk;
  assign bclkOe  = ctrl.enable && isMaster;
  assign wsOe    = ctrl.enable && isMaster;
  assign sdOe    = ctrl.enable && !ctrl.recordMode;

  // ********************************************************
  // channel fifos, direction set by record mode
  // ********************************************************
  logic [1:0]  fInValid, fInReady, fOutValid, fOutReady;
  logic [1:0]  rxPush, txPop, dmaPop, dmaPush;
  logic [31:0] fOutData [2];
  logic [5:0]  fCount [2];
  logic [31:0] fInData, rxData;

  // record fills from the link, playback fills from the bus
  always_comb begin
    fInValid  = ctrl.recordMode ? rxPush : dmaPush;
    fOutReady = ctrl.recordMode ? dmaPop : txPop;
    fInData   = ctrl.recordMode ? rxData : HRDATA;
  end

  for (genvar g = 0; g < 2; g++) begin : gChan
    asd_fifo #(.W(`ASD_WORD_W), .D(`ASD_FIFO_DEPTH)) uFifo (
      .clk     (clk),
      .reset_n (reset_n),
      .flush   (!ctrl.enable),
      .inValid (fInValid[g]),
      .inReady (fInReady[g]),
      .inData  (fInData),
      .outValid(fOutValid[g]),
      .outReady(fOutReady[g]),
      .outData (fOutData[g]),
      .count   (fCount[g])
    );
  end

  // ********************************************************
  // receive path
  // ********************************************************
  logic [31:0] rxWord, next_rxWord, next_rxData, rxFull;
  logic [15:0] leftHalf, next_leftHalf;
  logic [1:0]  next_rxPush;
  logic        overrun, next_overrun;

  // msb-first fill; a codec cannot be stalled, so a full fifo drops and flags
  always_comb begin
    next_rxWord   = rxWord;
    next_rxData   = rxData;
    next_leftHalf = leftHalf;
    next_rxPush   = 2'h0;
    rxFull        = rxWord;
    next_overrun  = overrun && ctrl.enable;
    if (|(rxPush & ~fInReady)) begin
      next_overrun = 1'b1;
    end
    if (rise && ctrl.enable && ctrl.recordMode) begin
      if (pos == 5'h00) begin
        next_rxWord = '0;
      end else if (pos <= nb) begin
        rxFull[5'(~pos + 5'h01)] = sdS[1];
        next_rxWord = rxFull;
        if (pos == nb) begin
          if (isPacked && !slot) begin
            next_leftHalf = rxFull[31:16];
          end else begin
            next_rxPush = (isPacked || !slot) ? 2'h1 : 2'h2;
            next_rxData = isPacked ? {rxFull[31:16], leftHalf} : rxFull;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxWord   <= '0;
      rxData   <= '0;
      leftHalf <= '0;
      rxPush   <= 2'h0;
      overrun  <= 1'b0;
    end else begin
      rxWord   <= next_rxWord;
      rxData   <= next_rxData;
      leftHalf <= next_leftHalf;
      rxPush   <= next_rxPush;
      overrun  <= next_overrun;
    end
  end

  // ********************************************************
  // transmit path
  // ********************************************************
  logic [31:0] txShift, next_txShift;
  logic [15:0] txHold, next_txHold;
  logic        underrun, next_underrun, txCh;

  // load at the first data bit of a slot, shift on every later falling edge
  always_comb begin
    next_txShift  = txShift;
    next_txHold   = txHold;
    next_underrun = underrun && ctrl.enable;
    txPop         = 2'h0;
    txCh          = !isPacked && next_bitCnt[5];
    if (fall && ctrl.enable && !ctrl.recordMode) begin
      next_txShift = {txShift[30:0], 1'b0};
      if (next_bitCnt[4:0] == `ASD_FIRST_BIT) begin
        if (isPacked && next_bitCnt[5]) begin
          next_txShift = {txHold, 16'h0000};
        end else if (!fOutValid[txCh]) begin
          next_txShift  = '0;
          next_txHold   = '0;
          next_underrun = 1'b1;
        end else begin
          txPop[txCh]  = 1'b1;
          next_txHold  = fOutData[txCh][31:16];
          next_txShift = isPacked ? {fOutData[txCh][15:0], 16'h0000}
                                  : (fOutData[txCh] & precMask(ctrl.precision));
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txShift  <= '0;
      txHold   <= '0;
      underrun <= 1'b0;
    end else begin
      txShift  <= next_txShift;
      txHold   <= next_txHold;
      underrun <= next_underrun;
    end
  end

  assign sdOut = txShift[31];

  // ********************************************************
  // ahb burst dma
  // ********************************************************
  asd_dma_st_t      st, next_st;
  logic             chan, next_chan, dPhase, next_dPhase, next_irq;
  logic [4:0]       addrCnt, next_addrCnt, dataCnt, next_dataCnt;
  logic [31:0]      haddr, next_haddr;
  logic [1:0][15:0] off, next_off;
  logic [15:0]      off1;
  logic [5:0]       room;

  // one burst per channel at a time, started only when it can finish unstalled
  always_comb begin
    next_st      = st;
    next_chan    = chan;
    next_dPhase  = dPhase;
    next_addrCnt = addrCnt;
    next_dataCnt = dataCnt;
    next_haddr   = haddr;
    next_off     = off;
    next_irq     = 1'b0;
    dmaPop       = 2'h0;
    dmaPush      = 2'h0;
    off1         = off[chan] + 16'h0001;
    room         = ctrl.recordMode ? fCount[chan] : `ASD_FIFO_FREE - fCount[chan];
    case (st)
      ASD_IDLE: begin
        if (ctrl.enable && (room >= {1'b0, nBeats})) begin
          next_st      = ASD_REQ;
          next_addrCnt = 5'h00;
          next_dataCnt = 5'h00;
          next_haddr   = (chan ? ctrl.baseRight : ctrl.baseLeft) + {14'h0000, off[chan], 2'h0};
        end
      end
      ASD_REQ: begin
        if (!ctrl.enable) begin
          next_st = ASD_IDLE;
        end else if (HGRANT && HREADY) begin
          next_st = ASD_BURST;
        end
      end
      ASD_BURST: begin
        if (HREADY) begin
          next_dPhase = (addrCnt != nBeats);
          if (addrCnt != nBeats) begin
            next_addrCnt = addrCnt + 5'h01;
            next_haddr   = haddr + `ASD_WORD_BYTES;
          end
          if (dPhase) begin
            next_dataCnt  = dataCnt + 5'h01;
            dmaPop[chan]  = ctrl.recordMode;
            dmaPush[chan] = !ctrl.recordMode;
            next_off[chan] = (off1 == ctrl.bufWords) ? 16'h0000 : off1;
            next_irq = !chan && ((off1 == (ctrl.bufWords >> 3)) || (off1 == (ctrl.bufWords >> 2)) ||
                                 (off1 == (ctrl.bufWords >> 1)) || (off1 == ctrl.bufWords));
            if (dataCnt + 5'h01 == nBeats) begin
              next_st     = ASD_IDLE;
              next_chan   = !isPacked && !chan;
              next_dPhase = 1'b0;
            end
          end
        end
      end
      default: next_st = ASD_IDLE;
    endcase
    // disabling between bursts rewinds both channels
    if (!ctrl.enable && (st != ASD_BURST)) begin
      next_chan = 1'b0;
      next_off  = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st      <= ASD_IDLE;
      chan    <= 1'b0;
      dPhase  <= 1'b0;
      addrCnt <= 5'h00;
      dataCnt <= 5'h00;
      haddr   <= '0;
      off     <= '0;
      dmaIrq  <= 1'b0;
    end else begin
      st      <= next_st;
      chan    <= next_chan;
      dPhase  <= next_dPhase;
      addrCnt <= next_addrCnt;
      dataCnt <= next_dataCnt;
      haddr   <= next_haddr;
      off     <= next_off;
      dmaIrq  <= next_irq;
    end
  end

  // bus outputs; lock rides with the request through the last data phase
  assign HBUSREQ = (st == ASD_REQ) || (st == ASD_BURST);
  assign HLOCK   = (st == ASD_REQ) || (st == ASD_BURST);
  assign HTRANS  = ((st == ASD_BURST) && (addrCnt != nBeats))
                   ? ((addrCnt == 5'h00) ? `ASD_HTRANS_NONSEQ : `ASD_HTRANS_SEQ) : `ASD_HTRANS_IDLE;
  assign HBURST  = (nBeats == `ASD_BEATS_4) ? `ASD_HBURST_INCR4
                 : (nBeats == `ASD_BEATS_8) ? `ASD_HBURST_INCR8 : `ASD_HBURST_INCR16;
  assign HSIZE   = `ASD_HSIZE_WORD;
  assign HWRITE  = ctrl.recordMode;
  assign HADDR   = haddr;
  assign HWDATA  = fOutData[chan];
  assign stat    = '{busy: (st != ASD_IDLE), overrun: overrun, underrun: underrun};

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic nonseq;
  assign nonseq = (HTRANS == `ASD_HTRANS_NONSEQ);

  AST_BURST_PACKED: assert property (nonseq && isPacked |-> HBURST == (ctrl.burstDepthSelect ? 3'h3 : 3'h5))
    else $error("packed burst type wrong");
  AST_BURST_WIDE: assert property (nonseq && !isPacked |-> HBURST == (ctrl.burstDepthSelect ? 3'h5 : 3'h7))
    else $error("wide burst type wrong");
  AST_BEATS: assert property ($fell(st == ASD_BURST) |-> $past(addrCnt) == (isPacked ?
      (ctrl.burstDepthSelect ? 5'h04 : 5'h08) : (ctrl.burstDepthSelect ? 5'h08 : 5'h10)))
    else $error("burst beat count wrong");
  AST_LOCK: assert property ((HTRANS != `ASD_HTRANS_IDLE) || (dPhase && st == ASD_BURST) |-> HLOCK)
    else $error("lock dropped inside burst");
  AST_SEQ_FOLLOWS: assert property (nonseq && HREADY |=> HTRANS == `ASD_HTRANS_SEQ)
    else $error("burst did not continue");
  AST_ZERO_PAD: assert property (st == ASD_BURST && dPhase && HWRITE && !isPacked
      |-> (HWDATA & ~precMask(ctrl.precision)) == 32'h0000_0000)
    else $error("padding bits not zero");
  AST_BASE: assert property (nonseq |-> HADDR == (chan ? ctrl.baseRight : ctrl.baseLeft)
      + {14'h0000, off[chan], 2'h0})
    else $error("burst start address wrong");
  AST_WRAP: assert property (st == ASD_BURST && HREADY && dPhase && off[chan] + 16'h0001 == ctrl.bufWords
      |=> off[$past(chan)] == 16'h0000)
    else $error("buffer did not wrap");
  AST_IRQ: assert property (dmaIrq |-> off[0] == (ctrl.bufWords >> 3) || off[0] == (ctrl.bufWords >> 2)
      || off[0] == (ctrl.bufWords >> 1) || off[0] == 16'h0000)
    else $error("progress interrupt off point");
  AST_PCM_CLOCK: assert property (ctrl.enable && ctrl.pcmMode && divCnt >= ctrl.clkDiv
      |=> bclkOut != $past(bclkOut) && bclkOe)
    else $error("pcm not driving bit clock");
  AST_SLAVE_OE: assert property (!ctrl.pcmMode && !ctrl.clkMaster |-> !bclkOe && !wsOe)
    else $error("slave drives clock pins");

  COV_RECORD_BURST: cover property (HWRITE && nonseq && HREADY);
  COV_PLAY_BURST: cover property (!HWRITE && nonseq && HREADY);
  COV_IRQ: cover property (dmaIrq);
  COV_WRAP: cover property (dmaIrq && off[0] == 16'h0000);
endmodule : asd_port

// *** tb/asd_codec_model.sv ***
// codec model: slave-side bit clock, word select and record data
module asd_codec_model #(
  parameter logic [31:0] LEFT  = 32'hC3A5_9E71,
  parameter logic [31:0] RIGHT = 32'h5A3C_81F6
) (
  input  wire logic run,
  output logic      bclk,
  output logic      ws,
  output logic      sd
);
  timeunit 1ns;
  timeprecision 100ps;
  int pos;
  // clock stands still while stopped; the released data line keeps toggling
  initial begin
    bclk = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
    pos = 0;
    forever begin
      #62.5;
      if (run) begin
        bclk = ~bclk;
        if (!bclk) begin
          pos = (pos + 1) % 64;
          ws = (pos >= 32); // ws low carries the left slot
          sd = ws ? RIGHT[(32 - pos % 32) % 32] : LEFT[(32 - pos % 32) % 32]; // msb at bit one
        end
      end else begin
        sd = ~sd;
      end
    end
  end
endmodule : asd_codec_model

// *** tb/audio_serial_dma_port_tb.sv ***
// testbench for the audio serial dma port
`include "asd_consts.svh"
module audio_serial_dma_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import asd_pkg::*;
  typedef struct {asd_prec_t p; logic sel; logic rec;} asd_row_t;
  localparam logic [31:0] BL = 32'h0000_1000;
  localparam logic [31:0] BR = 32'h0000_2000;
  localparam logic [31:0] LP = 32'hC3A5_9E71;
  localparam logic [31:0] RP = 32'h5A3C_81F6;
  asd_row_t rows[8] = '{'{ASD_P8, 0, 0}, '{ASD_P16, 0, 0}, '{ASD_P18, 1, 0}, '{ASD_P24, 0, 0},
                        '{ASD_P16, 1, 0}, '{ASD_P20, 1, 1}, '{ASD_P16, 1, 1}, '{ASD_P24, 1, 1}};
  logic clk = 0, reset_n = 0, HGRANT = 0, HREADY = 1, dataPh = 0, grantOff = 0;
  logic [31:0] HRDATA = 0, HADDR, HWDATA;
  logic [1:0] HTRANS;
  logic [2:0] HBURST, HSIZE, expBurst;
  logic bclkOut, bclkOe, wsOut, wsOe, sdOut, sdOe, cBclk, cWs, cSd, dmaIrq, HBUSREQ, HLOCK, HWRITE;
  asd_ctrl_t ctrl = '{enable: 0, recordMode: 0, pcmMode: 0, clkMaster: 0, precision: ASD_P16,
                      burstDepthSelect: 0, clkDiv: 8'h03, baseLeft: BL, baseRight: BR, bufWords: 16'h0010};
  asd_stat_t stat;
  int bad_count = 0, checks = 0, cyc = 0, beatCnt = 0, irqCnt = 0, n;
  logic [31:0] starts[$], lens[$], words[$];
  always #4 clk = ~clk;
  asd_port dut (.clk(clk), .reset_n(reset_n), .ctrl(ctrl), .stat(stat), .dmaIrq(dmaIrq),
    .bclkIn(bclkOe ? bclkOut : cBclk), .bclkOut(bclkOut), .bclkOe(bclkOe), .wsIn(wsOe ? wsOut : cWs),
    .wsOut(wsOut), .wsOe(wsOe), .sdIn(cSd), .sdOut(sdOut), .sdOe(sdOe), .HBUSREQ(HBUSREQ), .HLOCK(HLOCK),
    .HGRANT(HGRANT), .HREADY(HREADY), .HADDR(HADDR), .HTRANS(HTRANS), .HBURST(HBURST), .HSIZE(HSIZE),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HRDATA(HRDATA));
  asd_codec_model codec (.run(ctrl.enable), .bclk(cBclk), .ws(cWs), .sd(cSd));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // memory side: grant, a stall every fourth cycle, beat monitor
  // ****************************************
  always @(posedge clk) begin
    HGRANT <= HBUSREQ && !grantOff;
    HREADY <= (cyc % 4 != 3); // stalls exercise the address hold
    if (dmaIrq === 1'b1) irqCnt++;
    if (HREADY) begin
      // read data belongs to the address just accepted and holds through stalls
      HRDATA <= {HADDR[15:0], ~HADDR[15:0]};
      if (dataPh && HWRITE) words.push_back(HWDATA);
      dataPh = HTRANS[1];
      if (HTRANS == `ASD_HTRANS_NONSEQ) begin
        starts.push_back(HADDR);
        if (beatCnt != 0) lens.push_back(beatCnt);
        beatCnt = 1;
      end else if (HTRANS == `ASD_HTRANS_SEQ) beatCnt++;
      if (HTRANS[1]) begin
        check("lock", HLOCK, 1);
        check("burst", HBURST, expBurst);
        check("size", HSIZE, `ASD_HSIZE_WORD);
      end
    end
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] expWord(asd_prec_t p);
    int b = (p == ASD_P8) ? 8 : (p == ASD_P18) ? 18 : (p == ASD_P20) ? 20 : 24;
    return (p == ASD_P16) ? {RP[31:16], LP[31:16]} : LP & (32'hFFFF_FFFF << (32 - b));
  endfunction : expWord
  initial begin
    repeat (6) @(posedge clk);
    check("idle trans", HTRANS, `ASD_HTRANS_IDLE);
    check("idle req", HBUSREQ, 0);
    reset_n <= 1;
    foreach (rows[i]) begin
      starts.delete();
      lens.delete();
      words.delete();
      irqCnt = 0;
      beatCnt = 0;
      n = (rows[i].p == ASD_P16) ? (rows[i].sel ? 4 : 8) : (rows[i].sel ? 8 : 16);
      expBurst = (n == 4) ? `ASD_HBURST_INCR4 : (n == 8) ? `ASD_HBURST_INCR8 : `ASD_HBURST_INCR16;
      ctrl.precision <= rows[i].p;
      ctrl.burstDepthSelect <= rows[i].sel;
      ctrl.recordMode <= rows[i].rec;
      @(posedge clk);
      ctrl.enable <= 1;
      if (rows[i].rec) begin
        while (words.size() < n) @(posedge clk);
        check("start", starts[0], BL);
        check("word", words[n-1], expWord(rows[i].p));
        check("overrun", stat.overrun, 0);
      end else begin
        while (starts.size() < 2) @(posedge clk);
        check("irqs", irqCnt, $clog2(n));
        while (starts.size() < 3) @(posedge clk);
        check("beats", lens[0], n);
        check("beats2", lens[1], n);
        for (int k = 0; k < 3; k++) begin
          check("addr", starts[k], (rows[i].p == ASD_P16) ? BL + (k * n * 4) % 64 :
                ((k % 2) ? BR : BL) + ((k / 2) * n * 4) % 64);
        end
      end
      while (stat.busy !== 1'b0) @(posedge clk);
      ctrl.enable <= 0;
      repeat (4) @(posedge clk);
    end
    // starved playback: the fifo runs dry and the link sends zeros
    grantOff <= 1;
    ctrl.recordMode <= 0;
    ctrl.enable <= 1;
    repeat (2000) @(posedge clk);
    check("underrun", stat.underrun, 1);
    check("slave clock", bclkOe, 0);
    check("data drive", sdOe, 1);
    check("zero data", sdOut, 0);
    ctrl.enable <= 0;
    @(posedge clk);
    ctrl.pcmMode <= 1;
    ctrl.enable <= 1;
    repeat (2) @(posedge clk);
    check("pcm clock", bclkOe, 1);
    check("pcm ws", wsOe, 1);
    repeat (3) @(posedge clk);
    check("pcm bclk", bclkOut, 1);
    repeat (5) @(posedge clk);
    check("pcm sync", wsOut, 1);
    tally_and_finish();
  end
endmodule : audio_serial_dma_port_tb
